// ===== omta_core.v
/*
  OTP mirror registers with serial test-mode access, device side.
  Assumes the serial clock, select and data arrive from outside the clock
  domain and are oversampled by clk, which must run well above the link rate.
  The OTP array contents arrive as a flat parallel bus that is stable at reset.
*/
// Notes on behaviour
// - Write frame shifts out old register value
// - Copy OTP into mirrors within sixteen cycles
// - Test mode lets master overwrite mirrors
// - Mirror writes need allow flag 0x29 bit5
// - Writing zero to 0x20 sets allow flag
// - Frame: 6 address, direction, 1 unused, 8 data, MSB first
// - Direction one writes, zero reads
// - Write data captured on rises 9 to 16
// - Mode zero: sample rise, change fall
`include "omta_regs.vh"

module omta_core #(
  parameter DEPTH = `OMTA_MIRROR_DEPTH
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // OTP array contents, entry i at bits [8*i+7:8*i]
  input wire [DEPTH*8-1:0] otp_data,
  // Test mode
  input wire test_mode,
  // Serial link
  input wire spi_clk,
  input wire spi_cs_n,
  input wire spi_din,
  output reg spi_dout,
  output reg spi_dout_oe,
  // Status
  output reg load_done,
  output reg mirror_wr_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Link inputs cross into the clk domain through two flip-flops each. The
  // clock must run several times faster than the link so that every link
  // level is held for more than one clk cycle and no edge is lost.
  wire sclk_s;
  wire cs_n_s;
  wire din_s;
  wire tmode_s;

  omta_sync u_sync_clk (.clk(clk), .arst_n(arst_n), .din(spi_clk), .dout(sclk_s));
  omta_sync u_sync_cs (.clk(clk), .arst_n(arst_n), .din(spi_cs_n), .dout(cs_n_s));
  omta_sync u_sync_din (.clk(clk), .arst_n(arst_n), .din(spi_din), .dout(din_s));
  omta_sync u_sync_tm (.clk(clk), .arst_n(arst_n), .din(test_mode), .dout(tmode_s));

  reg sclk_prev_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  wire rise = sclk_s & ~sclk_prev_q;
  wire fall = ~sclk_s & sclk_prev_q;
  // The select and test mode pass the same synchroniser depth, so they agree.
  wire active = ~cs_n_s & tmode_s;

  ////////////////////////////////////////////////////////////////////////////
  // The mirrors copy the OTP array on the first clock after reset and the
  // done flag follows one clock later; link edges before that are ignored.
  reg [4:0] load_cnt_q;
  reg [4:0] load_cnt_d;
  reg load_done_d;
  wire load_now = ~load_done & (load_cnt_q == 5'h00);

  always @* begin
    load_cnt_d = load_cnt_q;
    load_done_d = load_done;
    if (!load_done) begin
      load_cnt_d = load_cnt_q + 5'h01;
      if (load_cnt_q == 5'h01) begin
        load_done_d = 1'b1;
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      load_cnt_q <= 5'h00;
      load_done <= 1'b0;
    end else begin
      load_cnt_q <= load_cnt_d;
      load_done <= load_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame receive on rising edges. The count stops at a full frame so that
  // stray extra clocks cannot start a second address phase in one select.
  reg [4:0] rx_cnt_q;
  reg [4:0] rx_cnt_d;
  reg [5:0] addr_q;
  reg [5:0] addr_d;
  reg rw_q;
  reg rw_d;
  reg [7:0] wdata_q;
  reg [7:0] wdata_d;
  reg commit_q;
  reg commit_d;

  always @* begin
    rx_cnt_d = rx_cnt_q;
    addr_d = addr_q;
    rw_d = rw_q;
    wdata_d = wdata_q;
    commit_d = 1'b0;
    if (!active) begin
      rx_cnt_d = 5'h00;
    end else if (rise && load_done && rx_cnt_q < `OMTA_FRAME_BITS) begin
      rx_cnt_d = rx_cnt_q + 5'h01;
      if (rx_cnt_q < `OMTA_ADDR_BITS) begin
        addr_d = {addr_q[4:0], din_s};
      end else if (rx_cnt_q == `OMTA_ADDR_BITS) begin
        rw_d = din_s;
      end else if (rx_cnt_q >= `OMTA_WR_FIRST_RISE - 1) begin
        wdata_d = {wdata_q[6:0], din_s};
        if (rx_cnt_q == `OMTA_FRAME_BITS - 1 && rw_q) begin
          commit_d = 1'b1;
        end
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_cnt_q <= 5'h00;
      addr_q <= 6'h00;
      rw_q <= 1'b0;
      wdata_q <= 8'h00;
      commit_q <= 1'b0;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      wdata_q <= wdata_d;
      commit_q <= commit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The allow flag is set by writing the enable value to the control
  // location, whatever its own state, and only reset clears it.
  wire ctrl_hit = commit_q & (addr_q == `OMTA_ADDR_CTRL) & (wdata_q == `OMTA_CTRL_ENABLE_VAL);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mirror_wr_en <= 1'b0;
    end else if (ctrl_hit) begin
      mirror_wr_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mirror storage, one register per entry, read through a flat bus.
  wire [DEPTH*8-1:0] mirror_flat;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_mirror
      reg [7:0] ent_q;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          ent_q <= 8'h00;
        end else if (load_now) begin
          ent_q <= otp_data[gi*8 +: 8];
        end else if (commit_q && mirror_wr_en && addr_q == gi) begin
          ent_q <= wdata_q;
        end
      end
      assign mirror_flat[gi*8 +: 8] = ent_q;
    end
  endgenerate

  // Status location shows the allow flag; other locations read the mirror.
  wire [7:0] status_val = {7'h00, mirror_wr_en} << `OMTA_WEN_BIT;
  wire [7:0] rd_val = (addr_q == `OMTA_ADDR_STATUS) ? status_val : mirror_flat[{addr_q, 3'h0} +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Output on falling edges. The value is snapshotted at the 8th fall, before
  // any data capture of this frame, so a write returns the old contents.
  // After the 15th fall the last bit simply stands until the select ends.
  reg [4:0] fall_cnt_q;
  reg [4:0] fall_cnt_d;
  reg [7:0] tx_q;
  reg [7:0] tx_d;
  reg spi_dout_d;
  reg spi_dout_oe_d;

  always @* begin
    fall_cnt_d = fall_cnt_q;
    tx_d = tx_q;
    spi_dout_d = spi_dout;
    spi_dout_oe_d = 1'b1;
    if (!active) begin
      fall_cnt_d = 5'h00;
      spi_dout_d = 1'b0;
      spi_dout_oe_d = 1'b0;
    end else if (fall && load_done && fall_cnt_q < `OMTA_OUT_LAST_FALL) begin
      fall_cnt_d = fall_cnt_q + 5'h01;
      if (fall_cnt_q == `OMTA_OUT_FIRST_FALL - 1) begin
        tx_d = {rd_val[6:0], 1'b0};
        spi_dout_d = rd_val[7];
      end else if (fall_cnt_q >= `OMTA_OUT_FIRST_FALL) begin
        tx_d = {tx_q[6:0], 1'b0};
        spi_dout_d = tx_q[7];
      end
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fall_cnt_q <= 5'h00;
      tx_q <= 8'h00;
      spi_dout <= 1'b0;
      spi_dout_oe <= 1'b0;
    end else begin
      fall_cnt_q <= fall_cnt_d;
      tx_q <= tx_d;
      spi_dout <= spi_dout_d;
      spi_dout_oe <= spi_dout_oe_d;
    end
  end

endmodule // omta_core

// ===== omta_regs.vh
/*
  Constants for the OTP mirror test-access block: frame layout, addresses,
  flag positions and timing counts.
  Assumes it is included by bare name from the block's design files.
*/
`ifndef OMTA_REGS_VH
`define OMTA_REGS_VH

`define OMTA_FRAME_BITS 16
`define OMTA_ADDR_BITS 6
`define OMTA_DATA_BITS 8
`define OMTA_ADDR_CTRL 6'h20
`define OMTA_ADDR_STATUS 6'h29
`define OMTA_WEN_BIT 5
`define OMTA_CTRL_ENABLE_VAL 8'h00
`define OMTA_LOAD_CYCLES 16
`define OMTA_MIRROR_DEPTH 64
`define OMTA_WR_FIRST_RISE 9
`define OMTA_OUT_FIRST_FALL 8
`define OMTA_OUT_LAST_FALL 15

`endif

// ===== omta_sync.v
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes clk is the block clock and arst_n an asynchronous active-low reset.
*/
module omta_sync (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Signal
  input wire din,
  output wire dout
);

  reg meta_q;
  reg sync_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // omta_sync

// ===== omta_core_chk.sv
/*
  Concurrent checks on the ports of omta_core.
  Assumes it is bound into omta_core and that every check runs on clk and arst_n.
*/
module omta_core_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs watched for context
  input wire logic test_mode,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  // Outputs under check
  input wire logic spi_dout,
  input wire logic spi_dout_oe,
  input wire logic load_done,
  input wire logic mirror_wr_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_load_in_time: assert property ($rose(arst_n) |-> ##[0:16] load_done) else $error("load late");
  a_flag_kept: assert property (!$fell(mirror_wr_en)) else $error("flag fell");
  a_flag_after_load: assert property (!load_done |-> !mirror_wr_en) else $error("flag early");
  a_flag_rise_cause: assert property ($rose(mirror_wr_en) |-> test_mode && load_done) else $error("flag");
  a_oe_idle: assert property (spi_cs_n [*4] |-> !spi_dout_oe) else $error("oe idle");
  a_dout_idle: assert property (spi_cs_n [*6] |-> !spi_dout) else $error("dout idle");
  a_dout_clk_low: assert property ($changed(spi_dout) |-> !spi_clk) else $error("dout edge");
  a_test_gate: assert property (!test_mode [*4] |-> !spi_dout_oe) else $error("oe test");
  a_oe_frame: assert property ((!spi_cs_n && test_mode && load_done) [*4] |-> spi_dout_oe) else $error("oe frame");
endmodule // omta_core_chk

// ===== omta_master.sv
/*
  Serial master model, mode zero, 160 ns link clock.
  Assumes the bench clock runs at 8 ns and that xfer is called one frame at a time.
*/
module omta_master (
  // Bench clock
  input wire logic clk,
  // Serial link
  output logic spi_clk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic spi_din = 1'b0,
  input wire logic spi_dout
);
  timeunit 1ns;
  timeprecision 1ps;
  // All link changes are made at bench clock edges so they never race the design.
  task automatic xfer(input logic [5:0] a, input logic rw, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, rw, 1'b0, d};
    q = 8'h00;
    spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_din <= f[i];
      repeat (10) @(posedge clk);
      spi_clk <= 1'b1;
      if (i < 8) q[i] = spi_dout;
      repeat (10) @(posedge clk);
      spi_clk <= 1'b0;
    end
    repeat (10) @(posedge clk);
    spi_cs_n <= 1'b1;
    // A released line must not look like held data.
    spi_din <= ~spi_din;
    repeat (20) @(posedge clk);
  endtask
endmodule // omta_master

// ===== omta_core_bench.sv
/* Self-checking bench for omta_core.
   Assumes omta_master and omta_core_chk are compiled first. */
module omta_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, test_mode = 0;
  logic [511:0] otp_data;
  wire spi_clk, spi_cs_n, spi_din, spi_dout, spi_dout_oe, load_done, mirror_wr_en;
  int n_fail = 0, samples_checked = 0;
  logic [7:0] q;
  always #4 clk = ~clk;
  omta_core i_omta_core (.clk(clk), .arst_n(arst_n), .otp_data(otp_data), .test_mode(test_mode),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe), .load_done(load_done), .mirror_wr_en(mirror_wr_en));
  omta_master i_omta_master (.clk(clk), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_din(spi_din),
    .spi_dout(spi_dout));
  function automatic logic [7:0] otp(int a);
    return 8'(a) ^ 8'h96;
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(logic [5:0] a, logic rw, logic [7:0] d);
    i_omta_master.xfer(a, rw, d, q);
  endtask
  task automatic t_load;
    chk({7'h00, load_done}, 8'h01);
    fork
      xf(6'h05, 0, 0);
      begin
        repeat (100) @(posedge clk);
        chk({7'h00, spi_dout_oe}, 8'h01);
      end
    join
    chk(q, otp(5));
    chk({7'h00, spi_dout_oe}, 8'h00);
    xf(6'h3f, 0, 0);
    chk(q, otp(63));
    $display("load test done");
  endtask
  task automatic t_refused;
    xf(6'h05, 1, 8'h5a);
    chk(q, otp(5));
    xf(6'h05, 0, 0);
    chk(q, otp(5));
    xf(6'h29, 0, 0);
    chk(q, 8'h00);
    $display("refusal test done");
  endtask
  task automatic t_unlock;
    xf(6'h20, 1, 8'h00);
    chk({7'h00, mirror_wr_en}, 8'h01);
    xf(6'h29, 0, 0);
    chk(q, 8'h20);
    $display("unlock test done");
  endtask
  task automatic t_write;
    xf(6'h05, 1, 8'ha5);
    chk(q, otp(5));
    xf(6'h05, 1, 8'h3c);
    chk(q, 8'ha5);
    xf(6'h05, 0, 0);
    chk(q, 8'h3c);
    $display("write test done");
  endtask
  task automatic t_gate;
    test_mode <= 1'b0;
    repeat (4) @(posedge clk);
    xf(6'h05, 1, 8'h77);
    chk(q, 8'h00);
    test_mode <= 1'b1;
    repeat (4) @(posedge clk);
    xf(6'h05, 0, 0);
    chk(q, 8'h3c);
    $display("test mode gate test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 64; i++) otp_data[i*8+:8] = otp(i);
    repeat (12) @(posedge clk);
    arst_n <= 1;
    test_mode <= 1;
    repeat (16) @(posedge clk);
    t_load;
    t_refused;
    t_unlock;
    t_write;
    t_gate;
    wrap_up;
  end
  initial begin
    #100us;
    n_fail++;
    wrap_up;
  end
endmodule // omta_core_bench
bind omta_core omta_core_chk i_omta_core_chk (.clk(clk), .arst_n(arst_n), .test_mode(test_mode),
  .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
  .load_done(load_done), .mirror_wr_en(mirror_wr_en));
